// ===== hw/srw_pkg.sv
// Package with constants and types shared by both supervisor ends
// What this block does
// - Reset held low, released 200ms after supply
// - Supply dip below threshold forces reset low
// - Brownout mid-pulse restarts the full 200ms reset
// - Kick needed each timeout; else expired low
// - Watchdog cleared during reset or floating input
// - Watchdog counts once reset released, input driven
// - Short kick pulses count; each edge clears
// - Supply low forces expired output low
// - Floating kick makes expired a low-line flag
// - Manual reset input starts a reset pulse
// - Route expired into manual reset for resets
// - Warn low while sense below 1.2V reference
// - Warn into manual reset resets on sense
// - Expired stays low until watchdog cleared
// - Expired released at once when supply recovers
// - Reset held 200ms after manual reset rises
package srw_pkg;
  // Clock period in picoseconds
  localparam int unsigned CLK_PERIOD_PS = 10000;
  // Internal time base tick period, 1 us
  localparam int unsigned TICK_PERIOD_NS = 1000;
  localparam int unsigned TICK_CYCLES = (TICK_PERIOD_NS * 1000) / CLK_PERIOD_PS;
  // Interval figures as printed
  localparam int unsigned RESET_PULSE_MS = 200;
  localparam int unsigned BROWNOUT_EXT_MS = 100;
  localparam int unsigned WD_TIMEOUT_MS = 1600;
  localparam int unsigned WD_TIMEOUT_MIN_MS = 1000;
  // Tick counts derived from the time base
  localparam int unsigned RESET_TICKS = (RESET_PULSE_MS * 1000000) / TICK_PERIOD_NS;
  localparam int unsigned BROWNOUT_TICKS = (BROWNOUT_EXT_MS * 1000000) / TICK_PERIOD_NS;
  localparam int unsigned WD_TICKS = (WD_TIMEOUT_MS * 1000000) / TICK_PERIOD_NS;
  // Counter widths
  localparam int unsigned TB_W = 8;
  localparam int unsigned CNT_W = 24;
  // Synchroniser depth
  localparam int unsigned SYNC_STAGES = 3;
  // Supervisor reset states
  typedef enum logic [2:0] {
    SRW_RST_LOW = 3'h1,
    SRW_RST_HOLD = 3'h2,
    SRW_RST_RUN = 3'h4
  } srw_rst_state_t;
endpackage : srw_pkg

// ===== hw/srw_if.sv
// Interface joining supervisor and processor ends
`timescale 1ns/1ps
interface srw_if;
  logic manual_reset_n; // Active-low manual reset into supervisor
  logic watchdog_kick_in; // Kick level from processor
  logic watchdog_kick_oe; // Processor drives kick while high
  logic reset_n; // Active-low reset to processor
  logic watchdog_expired_n; // Active-low watchdog/low-line output
  logic power_fail_warn_n; // Active-low power-fail warning
  // Supervisor end
  modport dev (
    input manual_reset_n,
    input watchdog_kick_in,
    input watchdog_kick_oe,
    output reset_n,
    output watchdog_expired_n,
    output power_fail_warn_n
  );
  // Processor end
  modport host (
    output manual_reset_n,
    output watchdog_kick_in,
    output watchdog_kick_oe,
    input reset_n,
    input watchdog_expired_n,
    input power_fail_warn_n
  );
endinterface : srw_if

// ===== hw/srw_host.sv
// Processor end: kicks watchdog, optionally routes outputs into manual reset
`timescale 1ns/1ps
module srw_host (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic kick_i, // One-cycle request to toggle kick
  input wire logic kick_float_i, // Leave kick undriven
  input wire logic route_expired_i, // Tie expired into manual reset
  input wire logic route_warn_i, // Tie warning into manual reset
  input wire logic button_n_i, // Push-button, low when pressed
  srw_if.host link,
  output logic cpu_in_reset_o,
  output logic low_line_o,
  output logic power_fail_irq_o
);
  // Sync chains for supervisor outputs
  logic [srw_pkg::SYNC_STAGES-1:0] rst_s_q, rst_s_d;
  logic [srw_pkg::SYNC_STAGES-1:0] exp_s_q, exp_s_d;
  logic [srw_pkg::SYNC_STAGES-1:0] pfw_s_q, pfw_s_d;
  logic kick_q, kick_d; // Kick level
  logic oe_q, oe_d; // Kick drive enable
  logic mr_q, mr_d; // Manual reset drive
  logic inrst_q, inrst_d, lowl_q, lowl_d, irq_q, irq_d;

  // Next-state logic
  always_comb begin
    rst_s_d = {rst_s_q[srw_pkg::SYNC_STAGES-2:0], link.reset_n};
    exp_s_d = {exp_s_q[srw_pkg::SYNC_STAGES-2:0], link.watchdog_expired_n};
    pfw_s_d = {pfw_s_q[srw_pkg::SYNC_STAGES-2:0], link.power_fail_warn_n};
    // Toggle once per request; processor must do this each timeout
    kick_d = kick_i ? ~kick_q : kick_q;
    oe_d = ~kick_float_i;
    // Wired-AND of reset sources, as a board would do
    mr_d = button_n_i & (~route_expired_i | link.watchdog_expired_n)
      & (~route_warn_i | link.power_fail_warn_n);
    // Agreed stages only, to reject a single glitch
    inrst_d = (rst_s_q[2] == rst_s_q[1]) ? ~rst_s_q[2] : inrst_q;
    lowl_d = (exp_s_q[2] == exp_s_q[1]) ? ~exp_s_q[2] : lowl_q;
    irq_d = (pfw_s_q[2] == pfw_s_q[1]) ? ~pfw_s_q[2] : irq_q;
  end

  // Registers
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      rst_s_q <= 3'h0;
      exp_s_q <= 3'h7;
      pfw_s_q <= 3'h7;
      kick_q <= 1'b0;
      oe_q <= 1'b0;
      mr_q <= 1'b1;
      inrst_q <= 1'b1;
      lowl_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      rst_s_q <= rst_s_d;
      exp_s_q <= exp_s_d;
      pfw_s_q <= pfw_s_d;
      kick_q <= kick_d;
      oe_q <= oe_d;
      mr_q <= mr_d;
      inrst_q <= inrst_d;
      lowl_q <= lowl_d;
      irq_q <= irq_d;
    end
  end

  assign link.watchdog_kick_in = kick_q;
  assign link.watchdog_kick_oe = oe_q;
  assign link.manual_reset_n = mr_q;
  assign cpu_in_reset_o = inrst_q;
  assign low_line_o = lowl_q;
  assign power_fail_irq_o = irq_q;
endmodule : srw_host

// ===== hw/srw_dev.sv
// Supervisor end: reset pulse generator, watchdog and power-fail pass-through
`timescale 1ns/1ps
module srw_dev #(
  parameter int unsigned RESET_TICKS = srw_pkg::RESET_TICKS, // Reset pulse length in ticks
  parameter int unsigned BROWNOUT_TICKS = srw_pkg::BROWNOUT_TICKS, // Brownout extension
  parameter int unsigned WD_TICKS = srw_pkg::WD_TICKS, // Watchdog timeout
  parameter int unsigned TICK_CYCLES = srw_pkg::TICK_CYCLES // Clocks per tick
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic supply_low_i, // Supply comparator, high while below threshold
  input wire logic power_fail_sense_in_i, // High while sense below 1.2V
  srw_if.dev link
);
  // Index of each input in the synchroniser bank
  localparam int unsigned N = 5; // Synchronised inputs
  localparam int unsigned I_SUP = 0;
  localparam int unsigned I_PF = 1;
  localparam int unsigned I_MR = 2;
  localparam int unsigned I_KICK = 3;
  localparam int unsigned I_OE = 4;
  // Terminal counts; every counter starts from zero, hence the minus one
  localparam logic [srw_pkg::CNT_W-1:0] RST_LAST = srw_pkg::CNT_W'(RESET_TICKS - 1);
  localparam logic [srw_pkg::CNT_W-1:0] BO_LAST = srw_pkg::CNT_W'(BROWNOUT_TICKS - 1);
  localparam logic [srw_pkg::CNT_W-1:0] WD_LAST = srw_pkg::CNT_W'(WD_TICKS - 1);
  localparam logic [srw_pkg::TB_W-1:0] TB_LAST = srw_pkg::TB_W'(TICK_CYCLES - 1);

  logic [N-1:0] raw; // Unsynchronised inputs
  logic [N-1:0] filt_q; // Accepted levels
  logic [N-1:0] filt_d; // Next accepted levels
  logic [srw_pkg::SYNC_STAGES-1:0] sync_q [N]; // Per-input chains
  logic [srw_pkg::SYNC_STAGES-1:0] sync_d [N]; // Chains shifted by one
  logic [srw_pkg::TB_W-1:0] tb_q; // Free-running prescaler
  logic [srw_pkg::TB_W-1:0] tb_d; // Prescaler next value
  logic tick_q; // One-cycle tick
  logic tick_d; // Tick next value
  srw_pkg::srw_rst_state_t st_q; // Reset sequencer state
  srw_pkg::srw_rst_state_t st_d; // Sequencer next state
  logic [srw_pkg::CNT_W-1:0] rcnt_q; // Reset pulse counter
  logic [srw_pkg::CNT_W-1:0] rcnt_d; // Reset counter next value
  logic [srw_pkg::CNT_W-1:0] wcnt_q; // Watchdog counter
  logic [srw_pkg::CNT_W-1:0] wcnt_d; // Watchdog counter next value
  logic kick_prev_q; // Kick level last cycle
  logic kick_prev_d; // Kick level to remember
  logic timeout_q; // Sticky watchdog timeout
  logic timeout_d; // Timeout next value
  logic rst_n_q; // Registered reset output
  logic rst_n_d; // Reset output next value
  logic exp_n_q; // Registered expired output
  logic exp_n_d; // Expired output next value
  logic pfw_n_q; // Registered warning output
  logic pfw_n_d; // Warning output next value
  logic sup_low; // Accepted supply-low level
  logic pf_low; // Accepted sense-low level
  logic mr_low; // Accepted manual reset, active high here
  logic kick_lvl; // Accepted kick level
  logic kick_drv; // Kick is driven, not floating
  logic kick_edge; // Either edge on a driven kick

  // Bank of raw inputs, all active high; manual reset is inverted here
  // so that a reset-to-zero filter reads every pin as inactive
  assign raw = {link.watchdog_kick_oe, link.watchdog_kick_in, ~link.manual_reset_n,
    power_fail_sense_in_i, supply_low_i};

  // Three-stage synchroniser per input, change taken when stages 2 and 3 agree
  genvar gi;
  generate
    for (gi = 0; gi < N; gi++) begin : g_sync
      // Shift in the raw pin; stage 0 feeds only stage 1
      assign sync_d[gi] = {sync_q[gi][srw_pkg::SYNC_STAGES-2:0], raw[gi]};
      // Chain registers only
      always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
          sync_q[gi] <= '0;
        end else begin
          sync_q[gi] <= sync_d[gi];
        end
      end
      // Agreement of stages 2 and 3 absorbs one metastable sample
      assign filt_d[gi] = (sync_q[gi][2] == sync_q[gi][1]) ? sync_q[gi][2] : filt_q[gi];
    end
  endgenerate

  assign sup_low = filt_q[I_SUP];
  assign pf_low = filt_q[I_PF];
  assign mr_low = filt_q[I_MR];
  assign kick_lvl = filt_q[I_KICK];
  assign kick_drv = filt_q[I_OE];
  // Edge after sync; 50ns pulse spans several 10ns clocks
  assign kick_edge = kick_drv & (kick_lvl ^ kick_prev_q);

  // Free-running time base; every interval counts ticks, never raw clocks
  always_comb begin
    tb_d = (tb_q == TB_LAST) ? '0 : tb_q + 1'b1;
    tick_d = (tb_q == TB_LAST);
  end

  // Time base registers
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      tb_q <= '0;
      tick_q <= 1'b0;
    end else begin
      tb_q <= tb_d;
      tick_q <= tick_d;
    end
  end

  // Reset sequencer: LOW while a cause stands, HOLD while timing, RUN when released
  always_comb begin
    st_d = st_q;
    rcnt_d = rcnt_q;
    case (st_q)
      srw_pkg::SRW_RST_LOW: begin
        // Held while supply low or manual reset low
        rcnt_d = '0;
        if (!sup_low && !mr_low) begin
          st_d = srw_pkg::SRW_RST_HOLD;
        end
      end
      srw_pkg::SRW_RST_HOLD: begin
        if (sup_low || mr_low) begin
          // Brownout mid-pulse: keep at least a further 100ms
          st_d = srw_pkg::SRW_RST_LOW;
          if (sup_low && rcnt_q > RST_LAST - BO_LAST) begin
            rcnt_d = '0;
          end
        end else if (tick_q) begin
          if (rcnt_q >= RST_LAST) begin
            st_d = srw_pkg::SRW_RST_RUN;
          end else begin
            rcnt_d = rcnt_q + 1'b1;
          end
        end
      end
      srw_pkg::SRW_RST_RUN: begin
        rcnt_d = '0;
        if (sup_low || mr_low) begin
          st_d = srw_pkg::SRW_RST_LOW;
        end
      end
      default: begin
        st_d = srw_pkg::SRW_RST_LOW;
        rcnt_d = '0;
      end
    endcase
    // Taken from the next state, so the output flop moves with the state
    rst_n_d = (st_d == srw_pkg::SRW_RST_RUN);
  end

  // Sequencer registers; reset output starts asserted
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      st_q <= srw_pkg::SRW_RST_LOW;
      rcnt_q <= '0;
      rst_n_q <= 1'b0;
    end else begin
      st_q <= st_d;
      rcnt_q <= rcnt_d;
      rst_n_q <= rst_n_d;
    end
  end

  // Watchdog and outputs
  // A kick edge in the cycle of expiry wins: the processor was still alive,
  // at the cost of one tick of extra grace
  always_comb begin
    kick_prev_d = kick_lvl;
    wcnt_d = wcnt_q;
    timeout_d = timeout_q;
    if (!rst_n_q || !kick_drv || kick_edge) begin
      // Cleared and stopped in reset or when floating
      wcnt_d = '0;
      timeout_d = 1'b0;
    end else if (tick_q && !timeout_q) begin
      // Counts as soon as released and driven
      if (wcnt_q >= WD_LAST) begin
        timeout_d = 1'b1;
      end else begin
        wcnt_d = wcnt_q + 1'b1;
      end
    end
    // Low-line term is combinational from sup_low, so recovery releases at once
    exp_n_d = ~(timeout_d | sup_low);
    pfw_n_d = ~pf_low;
  end

  // Input filter registers; pins read inactive until the chains fill,
  // which is harmless since HOLD cannot finish in those few cycles
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      filt_q <= '0;
    end else begin
      filt_q <= filt_d;
    end
  end

  // Watchdog and output registers; expired and warning idle high
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      wcnt_q <= '0;
      kick_prev_q <= 1'b0;
      timeout_q <= 1'b0;
      exp_n_q <= 1'b1;
      pfw_n_q <= 1'b1;
    end else begin
      wcnt_q <= wcnt_d;
      kick_prev_q <= kick_prev_d;
      timeout_q <= timeout_d;
      exp_n_q <= exp_n_d;
      pfw_n_q <= pfw_n_d;
    end
  end

  assign link.reset_n = rst_n_q;
  assign link.watchdog_expired_n = exp_n_q;
  assign link.power_fail_warn_n = pfw_n_q;
endmodule : srw_dev

// ===== tb/srw_link_sva.sv
// Checker on the link between supervisor and processor ends
`timescale 1ns/1ps
module srw_link_sva (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic supply_low_i,
  input wire logic power_fail_sense_in_i,
  input wire logic manual_reset_n,
  input wire logic watchdog_kick_in,
  input wire logic watchdog_kick_oe,
  input wire logic reset_n,
  input wire logic watchdog_expired_n,
  input wire logic power_fail_warn_n
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  logic [7:0] hold_d, hold_q; // Cycles reset low with no cause left
  logic [7:0] wd_d, wd_q; // Cycles since watchdog was last cleared
  logic kick_q; // Previous kick level
  // Saturating counters; sync delay is why bounds carry slack
  always_comb begin
    hold_d = (supply_low_i || !manual_reset_n || reset_n) ? 8'h00 : hold_q + {7'h00, hold_q != 8'hff};
    wd_d = (!reset_n || !watchdog_kick_oe || watchdog_kick_in != kick_q) ? 8'h00 : wd_q + {7'h00, wd_q != 8'hff};
  end
  // Registers only
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      hold_q <= 8'h00;
      wd_q <= 8'h00;
      kick_q <= 1'b0;
    end else begin
      hold_q <= hold_d;
      wd_q <= wd_d;
      kick_q <= watchdog_kick_in;
    end
  end
  AST_SUPPLY_RESET: assert property (supply_low_i [*6] |-> !reset_n) else $error("reset high in supply low");
  AST_SUPPLY_EXP: assert property (supply_low_i [*6] |-> !watchdog_expired_n) else $error("expired high");
  AST_HOLD_MIN: assert property ($rose(reset_n) |-> hold_q >= 8'h50) else $error("reset pulse short");
  AST_HOLD_MAX: assert property (hold_q <= 8'h60) else $error("reset pulse long");
  AST_MR_RESET: assert property (!manual_reset_n [*6] |-> !reset_n) else $error("manual reset ignored");
  AST_WARN_LOW: assert property (power_fail_sense_in_i [*6] |-> !power_fail_warn_n) else $error("warn high");
  AST_WARN_HIGH: assert property (!power_fail_sense_in_i [*6] |-> power_fail_warn_n) else $error("warn low");
  AST_WD_EARLY: assert property ($fell(watchdog_expired_n) && !supply_low_i |-> wd_q >= 8'hc4)
    else $error("watchdog expired early");
  AST_WD_LATE: assert property (wd_q >= 8'hd4 |-> !watchdog_expired_n) else $error("watchdog late");
  AST_WD_STICKY: assert property ($rose(watchdog_expired_n) |-> wd_q <= 8'h08) else $error("expired not sticky");
endmodule : srw_link_sva

// ===== tb/supervisor_reset_watchdog_bench.sv
// Bench joining both supervisor ends over the link
`timescale 1ns/1ps
module supervisor_reset_watchdog_bench;
  logic mclk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic supply_low = 1'b1; // Supply starts below threshold
  logic sense = 1'b0; // Sense above reference
  logic kick = 1'b0;
  logic kick_float = 1'b0;
  logic route_exp = 1'b0;
  logic route_warn = 1'b0;
  logic button_n = 1'b1;
  logic cpu_rst, low_line, pf_irq; // Host side flags
  int fails = 0;
  int samples_checked = 0;
  srw_if link_if ();
  // Short counts: pulse 80 cycles, brownout 40, watchdog 200
  srw_dev #(.RESET_TICKS(20), .BROWNOUT_TICKS(10), .WD_TICKS(50), .TICK_CYCLES(4)) srw_dev_i (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .supply_low_i(supply_low), .power_fail_sense_in_i(sense), .link(link_if));
  srw_host srw_host_i (.mclk_i(mclk_i), .resetn_i(resetn_i), .kick_i(kick), .kick_float_i(kick_float),
    .route_expired_i(route_exp), .route_warn_i(route_warn), .button_n_i(button_n), .link(link_if),
    .cpu_in_reset_o(cpu_rst), .low_line_o(low_line), .power_fail_irq_o(pf_irq));
  srw_link_sva srw_link_sva_i (.mclk_i(mclk_i), .resetn_i(resetn_i), .supply_low_i(supply_low),
    .power_fail_sense_in_i(sense), .manual_reset_n(link_if.manual_reset_n), .watchdog_kick_in(link_if.watchdog_kick_in),
    .watchdog_kick_oe(link_if.watchdog_kick_oe), .reset_n(link_if.reset_n),
    .watchdog_expired_n(link_if.watchdog_expired_n), .power_fail_warn_n(link_if.power_fail_warn_n));
  // Free-running 100 MHz clock
  initial begin
    forever #5 mclk_i = ~mclk_i;
  end
  // Step past edges; inputs always move 1 ns after the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask : cyc
  task automatic chk(input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t exp %0h got %0h", $time, exp, got);
    end
  endtask : chk
  // Bounded wait for reset release, judged against a window
  task automatic rel(input int lo, input int hi);
    int n;
    n = 0;
    while (link_if.reset_n !== 1'b1 && n < hi) begin
      cyc(1);
      n++;
    end
    chk(1'b1, link_if.reset_n === 1'b1 && n >= lo);
  endtask : rel
  task automatic kick_once();
    kick = 1'b1;
    cyc(1);
    kick = 1'b0;
  endtask : kick_once
  task automatic t_power_up();
    cyc(20);
    chk(1'b0, link_if.reset_n);
    supply_low = 1'b0;
    rel(80, 100);
  endtask : t_power_up
  // Dip, then a second dip in mid-pulse
  task automatic t_brownout();
    supply_low = 1'b1;
    cyc(20);
    chk(1'b0, link_if.reset_n);
    chk(1'b0, link_if.watchdog_expired_n);
    chk(1'b1, low_line);
    chk(1'b1, cpu_rst);
    supply_low = 1'b0;
    cyc(8);
    chk(1'b1, link_if.watchdog_expired_n);
    cyc(30);
    supply_low = 1'b1;
    cyc(10);
    supply_low = 1'b0;
    rel(80, 100);
  endtask : t_brownout
  task automatic t_manual();
    button_n = 1'b0;
    cyc(20);
    chk(1'b0, link_if.reset_n);
    button_n = 1'b1;
    rel(80, 100);
  endtask : t_manual
  task automatic t_warn();
    sense = 1'b1;
    cyc(10);
    chk(1'b0, link_if.power_fail_warn_n);
    chk(1'b1, pf_irq);
    route_warn = 1'b1;
    cyc(10);
    chk(1'b0, link_if.reset_n);
    sense = 1'b0;
    cyc(10);
    chk(1'b1, link_if.power_fail_warn_n);
    route_warn = 1'b0;
    rel(60, 100);
  endtask : t_warn
  task automatic t_watchdog();
    repeat (3) begin
      kick_once();
      cyc(150);
      chk(1'b1, link_if.watchdog_expired_n);
    end
    cyc(220);
    chk(1'b0, link_if.watchdog_expired_n);
    cyc(50);
    chk(1'b0, link_if.watchdog_expired_n);
    kick_once();
    cyc(8);
    chk(1'b1, link_if.watchdog_expired_n);
  endtask : t_watchdog
  // Timeout routed into manual reset
  task automatic t_route();
    route_exp = 1'b1;
    cyc(220);
    chk(1'b0, link_if.reset_n);
    route_exp = 1'b0;
    rel(0, 100);
  endtask : t_route
  // Floating kick leaves only the low-line role
  task automatic t_float();
    kick_float = 1'b1;
    cyc(300);
    chk(1'b1, link_if.watchdog_expired_n);
    supply_low = 1'b1;
    cyc(20);
    chk(1'b0, link_if.watchdog_expired_n);
    supply_low = 1'b0;
    cyc(8);
    chk(1'b1, link_if.watchdog_expired_n);
    rel(70, 100);
  endtask : t_float
  task automatic close_out();
    if (fails == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : close_out
  // Main sequence
  initial begin
    cyc(2);
    resetn_i = 1'b1;
    t_power_up();
    t_brownout();
    t_manual();
    t_warn();
    t_watchdog();
    t_route();
    t_float();
    close_out();
  end
  // Hang guard, well past the expected 2000 cycles
  initial begin
    #100000;
    fails++;
    close_out();
  end
endmodule : supervisor_reset_watchdog_bench
